// File: verilog/axis_restore_stop_speed_ctrl.sv
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "axis_ctrl_defines.svh"

module axis_restore_stop_speed_ctrl
	import axis_ctrl_pkg::*;
#(
	parameter int AXES = 2
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        srst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Amplifier side
	input  wire amp_in_s     ampIn0,
	input  wire amp_in_s     ampIn1,
	output amp_out_s         ampOut0,
	output amp_out_s         ampOut1,
	// Flags
	output logic [AXES-1:0]  axisBusy,
	output logic [AXES-1:0]  axisPosDone,
	output logic             globalErrorFlag
);

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	logic [1:0]        axisUse_r;
	logic [15:0]       spdAcc_r;
	logic [15:0]       spdDec_r;
	logic [31:0]       spdNew_r;
	logic [15:0]       errorCodeWord_r;
	logic              globalErr_r;
	logic [31:0]       feed_r [AXES];
	logic [31:0]       speedAct_r [AXES];
	logic [15:0]       accAct_r [AXES];
	logic [15:0]       decAct_r [AXES];
	logic signed [7:0] opState_r [AXES];
	logic [15:0]       axisErr_r [AXES];
	logic [AXES-1:0]   halt_r;
	logic [AXES-1:0]   busy_r;
	logic [AXES-1:0]   done_r;
	restore_e          rs_r [AXES];
	logic [31:0]       shift_r [AXES];
	logic [4:0]        pair_r [AXES];
	logic [15:0]       tmo_r [AXES];
	amp_in_s           ampIn [AXES];

	assign ampIn[0] = ampIn0;
	assign ampIn[1] = ampIn1;

	wire logic wrEn = psel & penable & pwrite;
	wire logic cmdWr = wrEn && (paddr == `OFS_CMD);
	wire logic [3:0] cmdCode = pwdata[3:0];
	wire logic cmdAxis = pwdata[4];

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (srst) begin
			axisUse_r <= 2'b00;
			spdAcc_r  <= 16'h0000;
			spdDec_r  <= 16'h0000;
			spdNew_r  <= 32'h0000_0000;
		end else if (wrEn) begin
			case (paddr)
				`OFS_CTRL:    axisUse_r <= pwdata[1:0];
				`OFS_SPD_ACC: spdAcc_r <= pwdata[15:0];
				`OFS_SPD_DEC: spdDec_r <= pwdata[15:0];
				`OFS_SPD_NEW: spdNew_r <= pwdata;
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Global error flag and code
	// ----------------------------------------
	wire logic cmdKnown = (cmdCode == `CMD_RESTORE) || (cmdCode == `CMD_HALT_ON) ||
		(cmdCode == `CMD_SPEED) || (cmdCode == `CMD_START) || (cmdCode == `CMD_BADDEV);

	always_ff @(posedge mclk) begin
		if (srst) begin
			globalErr_r     <= 1'b0;
			errorCodeWord_r <= 16'h0000;
		end else if (cmdWr && cmdKnown && !axisUse_r[cmdAxis]) begin
			globalErr_r     <= 1'b1;
			errorCodeWord_r <= `ERR_NOT_USED;
		end else if (cmdWr && cmdCode == `CMD_BADDEV) begin
			globalErr_r     <= 1'b1;
			errorCodeWord_r <= `ERR_BAD_DEVICE;
		end else if (cmdWr && cmdCode == `CMD_ERRCLR) begin
			globalErr_r     <= 1'b0;
			errorCodeWord_r <= 16'h0000;
		end
	end

	// ----------------------------------------
	// Per-axis command handling
	// ----------------------------------------
	for (genvar a = 0; a < AXES; a++) begin : g_axis
		wire logic hit = cmdWr && (cmdAxis == a) && axisUse_r[a];
		wire logic quiet = (opState_r[a] == `ST_STANDBY) || (opState_r[a] == `ST_STOPPED) ||
			(opState_r[a] == `ST_ERROR) || (opState_r[a] == `ST_DEC_STOP) ||
			(opState_r[a] == `ST_DEC_JOG) || (opState_r[a] == `ST_ANALYZE);
		wire logic restoring = (rs_r[a] != RS_IDLE);
		wire logic startReq = hit && (cmdCode == `CMD_RESTORE || cmdCode == `CMD_START);
		wire logic startOk = startReq && !halt_r[a] && !busy_r[a];
		// Done only when ready drops after the last pair, not the first
		wire logic rsDone = (rs_r[a] == RS_ACK) && !ampIn[a].ready &&
			(pair_r[a] == `RST_PAIRS);
		wire logic rsFail = restoring && (tmo_r[a] == `RST_TIMEOUT);

		// ----------------------------------------
		// Halt request, a level the program holds
		// ----------------------------------------
		always_ff @(posedge mclk) begin
			if (srst) begin
				halt_r[a] <= 1'b0;
			end else if (hit && cmdCode == `CMD_HALT_ON) begin
				halt_r[a] <= 1'b1;
			end else if (hit && cmdCode == `CMD_HALT_OFF) begin
				halt_r[a] <= 1'b0;
			end
		end

		// ----------------------------------------
		// Operation state
		// ----------------------------------------
		always_ff @(posedge mclk) begin
			if (srst) begin
				opState_r[a] <= `ST_STANDBY;
			end else if (rsFail) begin
				opState_r[a] <= `ST_ERROR;
			end else if (startOk && cmdCode == `CMD_RESTORE) begin
				opState_r[a] <= `ST_ANALYZE;
			end else if (startOk) begin
				opState_r[a] <= `ST_RUNNING;
			end else if (rsDone) begin
				opState_r[a] <= `ST_STANDBY;
			end else if (hit && cmdCode == `CMD_HALT_ON && !quiet && !restoring) begin
				opState_r[a] <= `ST_DEC_STOP;
			end else if (hit && cmdCode == `CMD_DECDONE && opState_r[a] == `ST_DEC_STOP) begin
				opState_r[a] <= `ST_STOPPED;
			end else if (hit && cmdCode == `CMD_ERRCLR && opState_r[a] == `ST_ERROR) begin
				opState_r[a] <= `ST_STANDBY;
			end
		end

		// ----------------------------------------
		// Axis error code
		// ----------------------------------------
		always_ff @(posedge mclk) begin
			if (srst) begin
				axisErr_r[a] <= 16'h0000;
			end else if (startReq && halt_r[a]) begin
				axisErr_r[a] <= `ERR_HALT_START;
			end else if (hit && cmdCode == `CMD_ERRCLR) begin
				axisErr_r[a] <= 16'h0000;
			end
		end

		// ----------------------------------------
		// Busy and positioning complete
		// ----------------------------------------
		always_ff @(posedge mclk) begin
			if (srst) begin
				busy_r[a] <= 1'b0;
				done_r[a] <= 1'b0;
			end else if (startOk) begin
				busy_r[a] <= 1'b1;
				done_r[a] <= 1'b0;
			end else if (rsDone) begin
				busy_r[a] <= 1'b0;
				done_r[a] <= 1'b1;
			end else if (rsFail || (hit && cmdCode == `CMD_DECDONE)) begin
				busy_r[a] <= 1'b0;
			end
		end

		// ----------------------------------------
		// Speed change
		// ----------------------------------------
		// Clamping keeps an out-of-range request from overrunning
		always_ff @(posedge mclk) begin
			if (srst) begin
				speedAct_r[a] <= 32'h0000_0000;
				accAct_r[a]   <= 16'h0000;
				decAct_r[a]   <= 16'h0000;
			end else if (hit && cmdCode == `CMD_SPEED && !quiet) begin
				speedAct_r[a] <= (spdNew_r > `SPEED_MAX) ? `SPEED_LIMIT : spdNew_r;
				accAct_r[a]   <= spdAcc_r;
				decAct_r[a]   <= spdDec_r;
			end
		end

		// ----------------------------------------
		// Restore handshake
		// ----------------------------------------
		// Servo on, request, take two bits per ready strobe
		always_ff @(posedge mclk) begin
			if (srst) begin
				rs_r[a]    <= RS_IDLE;
				pair_r[a]  <= 5'd0;
				shift_r[a] <= 32'h0000_0000;
				tmo_r[a]   <= 16'h0000;
			end else begin
				case (rs_r[a])
					RS_IDLE: begin
						tmo_r[a] <= 16'h0000;
						if (startOk && cmdCode == `CMD_RESTORE) begin
							rs_r[a]   <= RS_WAIT;
							pair_r[a] <= 5'd0;
						end
					end
					RS_WAIT: begin
						tmo_r[a] <= tmo_r[a] + 16'd1;
						if (rsFail) begin
							rs_r[a] <= RS_IDLE;
						end else if (ampIn[a].ready) begin
							shift_r[a] <= {ampIn[a].bit1, ampIn[a].bit0, shift_r[a][31:2]};
							rs_r[a]    <= RS_ACK;
							tmo_r[a]   <= 16'h0000;
						end
					end
					RS_ACK: begin
						tmo_r[a] <= tmo_r[a] + 16'd1;
						if (rsFail) begin
							rs_r[a] <= RS_IDLE;
						end else if (!ampIn[a].ready) begin
							pair_r[a] <= 5'(pair_r[a] + 5'd1);
							tmo_r[a]  <= 16'h0000;
							rs_r[a]   <= (pair_r[a] == `RST_PAIRS) ? RS_IDLE : RS_WAIT;
						end
					end
					default: rs_r[a] <= RS_IDLE;
				endcase
			end
		end

		// ----------------------------------------
		// Current feed value
		// ----------------------------------------
		// Only the last sixteen pairs survive in the 32-bit shifter
		always_ff @(posedge mclk) begin
			if (srst) begin
				feed_r[a] <= 32'h0000_0000;
			end else if (rs_r[a] == RS_ACK && !ampIn[a].ready && pair_r[a] == `RST_PAIRS) begin
				feed_r[a] <= shift_r[a];
			end
		end
	end

	// ----------------------------------------
	// Amplifier outputs and flags
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (srst) begin
			ampOut0 <= '0;
			ampOut1 <= '0;
		end else begin
			ampOut0.servoOn <= (rs_r[0] != RS_IDLE);
			ampOut0.request <= (rs_r[0] == RS_WAIT);
			ampOut0.spare   <= 1'b0;
			ampOut1.servoOn <= (rs_r[1] != RS_IDLE);
			ampOut1.request <= (rs_r[1] == RS_WAIT);
			ampOut1.spare   <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			axisBusy        <= '0;
			axisPosDone     <= '0;
			globalErrorFlag <= 1'b0;
		end else begin
			axisBusy        <= busy_r;
			axisPosDone     <= done_r;
			globalErrorFlag <= globalErr_r;
		end
	end

	// ----------------------------------------
	// APB read path, zero-wait
	// ----------------------------------------
	logic [31:0] rdMux;
	always_comb begin
		rdMux = 32'h0000_0000;
		case (paddr)
			`OFS_CTRL:     rdMux = {30'h0, axisUse_r};
			`OFS_SPD_ACC:  rdMux = {16'h0, spdAcc_r};
			`OFS_SPD_DEC:  rdMux = {16'h0, spdDec_r};
			`OFS_SPD_NEW:  rdMux = spdNew_r;
			`OFS_STAT0:    rdMux = {axisErr_r[0], opState_r[0], 4'h0, halt_r[0],
				globalErr_r, done_r[0], busy_r[0]};
			`OFS_STAT1:    rdMux = {axisErr_r[1], opState_r[1], 4'h0, halt_r[1],
				globalErr_r, done_r[1], busy_r[1]};
			`OFS_FEED0:    rdMux = feed_r[0];
			`OFS_FEED1:    rdMux = feed_r[1];
			`OFS_ERR:      rdMux = {16'h0, errorCodeWord_r};
			`OFS_SPD_ACT0: rdMux = speedAct_r[0];
			`OFS_SPD_ACT1: rdMux = speedAct_r[1];
			default:       rdMux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			prdata  <= rdMux;
			pslverr <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// File: verilog/axis_ctrl_defines.svh
`ifndef AXIS_CTRL_DEFINES_SVH
`define AXIS_CTRL_DEFINES_SVH

// Register byte offsets
`define OFS_CTRL       12'h000
`define OFS_CMD        12'h004
`define OFS_SPD_ACC    12'h008
`define OFS_SPD_DEC    12'h00C
`define OFS_SPD_NEW    12'h010
`define OFS_STAT0      12'h014
`define OFS_STAT1      12'h018
`define OFS_FEED0      12'h01C
`define OFS_FEED1      12'h020
`define OFS_ERR        12'h024
`define OFS_SPD_ACT0   12'h028
`define OFS_SPD_ACT1   12'h02C

// Command codes written to CMD[3:0], axis select in CMD[4]
`define CMD_RESTORE    4'h1
`define CMD_HALT_ON    4'h2
`define CMD_HALT_OFF   4'h3
`define CMD_SPEED      4'h4
`define CMD_START      4'h5
`define CMD_BADDEV     4'h6
`define CMD_ERRCLR     4'h7
`define CMD_DECDONE    4'h8

// Error codes
`define ERR_BAD_DEVICE 16'd4101
`define ERR_NOT_USED   16'd4116
`define ERR_HALT_START 16'd1102

// Axis status values
`define ST_STANDBY     8'sd0
`define ST_STOPPED     8'sd1
`define ST_ERROR       -8'sd1
`define ST_RUNNING     8'sd2
`define ST_DEC_STOP    8'sd7
`define ST_DEC_JOG     8'sd8
`define ST_ANALYZE     8'sd11

// Speed limits
`define SPEED_MAX      32'd200000
`define SPEED_LIMIT    32'd200000

// Restore handshake: 32 two-bit pairs
`define RST_PAIRS      5'd31
`define RST_TIMEOUT    16'hFFFF

`endif

// File: verilog/axis_ctrl_pkg.sv
package axis_ctrl_pkg;
	typedef enum logic [1:0] {
		RS_IDLE = 2'b00,
		RS_WAIT = 2'b01,
		RS_ACK  = 2'b10
	} restore_e;

	typedef struct packed {
		logic bit0;
		logic bit1;
		logic ready;
	} amp_in_s;

	typedef struct packed {
		logic servoOn;
		logic request;
		logic spare;
	} amp_out_s;
endpackage

// File: test/axis_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "axis_ctrl_defines.svh"

module axis_ctrl_sva
	import axis_ctrl_pkg::*;
#(
	parameter int AXES = 2
) (
	// Clock and bus
	input wire logic            mclk,
	input wire logic            srst,
	input wire logic            psel,
	input wire logic            penable,
	input wire logic            pwrite,
	input wire logic [11:0]     paddr,
	input wire logic [31:0]     pwdata,
	input wire logic            pready,
	// Axis side
	input wire amp_in_s         ampIn0,
	input wire amp_out_s        ampOut0,
	input wire logic [AXES-1:0] axisBusy,
	input wire logic [AXES-1:0] axisPosDone,
	input wire logic            globalErrorFlag
);
	logic cw;
	logic cw0;
	logic useR;
	assign cw = psel && penable && pwrite && paddr == `OFS_CMD;
	assign cw0 = cw && !pwdata[4];
	// Use bit is mirrored here so the busy check skips refused commands
	always_ff @(posedge mclk) begin
		if (srst)
			useR <= 1'b0;
		else if (psel && penable && pwrite && paddr == `OFS_CTRL)
			useR <= pwdata[0];
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	property p_busyRise;
		cw0 && pwdata[3:0] == `CMD_RESTORE && useR && !axisBusy[0] |-> ##2 axisBusy[0];
	endproperty
	a_busyRise: assert property (p_busyRise) else $error("busy late");
	property p_busyCause;
		$rose(axisBusy[0]) |-> $past(cw0, 2);
	endproperty
	a_busyCause: assert property (p_busyCause) else $error("busy cause");
	property p_reqServo;
		ampOut0.request |-> ampOut0.servoOn;
	endproperty
	a_reqServo: assert property (p_reqServo) else $error("request without servo on");
	property p_reqDrop;
		ampIn0.ready && ampOut0.request |-> ##[1:2] !ampOut0.request;
	endproperty
	a_reqDrop: assert property (p_reqDrop) else $error("request held");
	property p_doneEnd;
		$rose(axisPosDone[0]) |-> $fell(axisBusy[0]);
	endproperty
	a_doneEnd: assert property (p_doneEnd) else $error("done without busy end");
	property p_doneHold;
		$fell(axisPosDone[0]) |-> $past(cw0, 2);
	endproperty
	a_doneHold: assert property (p_doneHold) else $error("done lost");
	property p_errCause;
		$rose(globalErrorFlag) |-> $past(cw, 2);
	endproperty
	a_errCause: assert property (p_errCause) else $error("error flag cause");
	property p_ready;
		psel && !penable |=> pready;
	endproperty
	a_ready: assert property (p_ready) else $error("no ready");
	c_done: cover property ($rose(axisPosDone[0]));
	c_err: cover property ($rose(globalErrorFlag));
	c_busy1: cover property ($rose(axisBusy[1]));
endmodule

bind axis_restore_stop_speed_ctrl axis_ctrl_sva #(.AXES(AXES)) axis_ctrl_sva_i (
	.mclk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
	.ampIn0, .ampOut0, .axisBusy, .axisPosDone, .globalErrorFlag
);
`default_nettype wire

// File: test/amp_model.sv
`timescale 1ns/1ps
`default_nettype none

module amp_model
	import axis_ctrl_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic [63:0] pos,
	input  wire logic [3:0]  dly,
	input  wire amp_out_s    ampOut,
	output var amp_in_s      ampIn
);
	int k = 0;
	initial begin
		ampIn = 3'b000;
		forever begin
			@(posedge mclk);
			if (!ampOut.servoOn)
				k = 0;
			else if (ampOut.request) begin
				ampIn.bit0 <= pos[2*k];
				ampIn.bit1 <= pos[2*k+1];
				repeat (dly + 1) @(posedge mclk);
				ampIn.ready <= 1'b1;
				while (ampOut.request)
					@(posedge mclk);
				// Stale data would hide a late sample, so flip it
				ampIn <= {~ampIn.bit0, ~ampIn.bit1, 1'b0};
				k = (k + 1) % 32;
			end
		end
	end
endmodule
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "axis_ctrl_defines.svh"

module testbench
	import axis_ctrl_pkg::*;
;
	logic        mclk;
	logic        srst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	amp_in_s     ampIn0;
	amp_in_s     ampIn1;
	amp_out_s    ampOut0;
	amp_out_s    ampOut1;
	logic [1:0]  axisBusy;
	logic [1:0]  axisPosDone;
	logic        globalErrorFlag;
	logic [63:0] pos;
	logic [3:0]  dly;
	logic [31:0] seed;
	logic [31:0] rd;
	logic [31:0] v;
	int          n_errors = 0;
	int          n_compared = 0;
	int          cyc = 0;

	axis_restore_stop_speed_ctrl axis_restore_stop_speed_ctrl_i (
		.mclk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .ampIn0, .ampIn1, .ampOut0, .ampOut1, .axisBusy, .axisPosDone,
		.globalErrorFlag
	);
	amp_model amp_model_i (.mclk, .pos, .dly, .ampOut(ampOut0), .ampIn(ampIn0));
	amp_model amp_model_i1 (.mclk, .pos, .dly, .ampOut(ampOut1), .ampIn(ampIn1));

	function automatic logic [31:0] nx(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] lim(logic [31:0] s);
		return s > `SPEED_MAX ? `SPEED_MAX : s;
	endfunction
	task automatic report_and_stop();
		$display("errors=%0d compared=%0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(logic [31:0] s, logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			n_errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do
			@(posedge mclk);
		while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(logic [11:0] a, logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic cmd(logic [3:0] c, logic x);
		apb(1'b1, `OFS_CMD, {27'h000_0000, x, c});
	endtask
	task automatic rdc(logic [11:0] a, logic [31:0] e);
		apb(1'b0, a, '0);
		chk(rd, e);
	endtask
	task automatic st(logic x, logic [7:0] e);
		apb(1'b0, x ? `OFS_STAT1 : `OFS_STAT0, '0);
		chk(32'(rd[15:8]), 32'(e));
	endtask
	task automatic wt(logic x, logic e);
		int i;
		i = 0;
		while (axisBusy[x] !== e && i < 3000) begin
			@(posedge mclk);
			i++;
		end
		chk(32'(axisBusy[x]), 32'(e));
	endtask
	task automatic restore(logic x);
		seed = nx(seed);
		pos <= {seed, seed};
		dly <= seed[3:0];
		cmd(`CMD_RESTORE, x);
		wt(x, 1'b1);
		st(x, 8'h0B);
		cmd(`CMD_HALT_ON, x);
		st(x, 8'h0B);
		cmd(`CMD_HALT_OFF, x);
		wt(x, 1'b0);
		chk(32'(axisPosDone[x]), 32'h0000_0001);
		rdc(x ? `OFS_FEED1 : `OFS_FEED0, seed);
	endtask

	// ----
	// Clock, timeout and sequence
	// ----
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			report_and_stop();
		end
	end
	initial begin
		srst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		seed = 32'h0001_63E9;
		pos = '0;
		dly = '0;
		repeat (6) @(posedge mclk);
		srst <= 1'b0;
		rdc(`OFS_STAT0, '0);
		rdc(`OFS_FEED0, '0);
		wr(12'h030, 32'hFFFF_FFFF);
		rdc(12'h030, '0);
		chk(32'(pslverr), '0);
		wr(`OFS_CTRL, 32'h0000_0001);
		for (int c = 1; c < 6; c++) begin
			cmd(4'(c), 1'b1);
			rdc(`OFS_ERR, c == 3 ? 32'h0 : 32'(`ERR_NOT_USED));
			chk(32'(globalErrorFlag), c == 3 ? 32'h0 : 32'h1);
			cmd(`CMD_ERRCLR, 1'b0);
		end
		cmd(`CMD_BADDEV, 1'b0);
		rdc(`OFS_ERR, 32'(`ERR_BAD_DEVICE));
		cmd(`CMD_ERRCLR, 1'b0);
		wr(`OFS_SPD_NEW, 32'h0000_1000);
		cmd(`CMD_SPEED, 1'b0);
		rdc(`OFS_SPD_ACT0, '0);
		cmd(`CMD_HALT_ON, 1'b0);
		st(1'b0, 8'h00);
		cmd(`CMD_HALT_OFF, 1'b0);
		restore(1'b0);
		wr(`OFS_CTRL, 32'h0000_0003);
		restore(1'b1);
		chk(32'(axisPosDone[0]), 32'h0000_0001);
		cmd(`CMD_START, 1'b0);
		st(1'b0, 8'h02);
		chk(32'(axisPosDone[0]), '0);
		for (int i = 0; i < 5; i++) begin
			seed = nx(seed);
			v = i == 0 ? `SPEED_MAX : i == 1 ? `SPEED_MAX + 1 : {14'h0, seed[17:0]};
			wr(`OFS_SPD_NEW, v);
			cmd(`CMD_SPEED, 1'b0);
			rdc(`OFS_SPD_ACT0, lim(v));
		end
		cmd(`CMD_HALT_ON, 1'b0);
		st(1'b0, 8'h07);
		wr(`OFS_SPD_NEW, 32'h0000_0005);
		cmd(`CMD_SPEED, 1'b0);
		rdc(`OFS_SPD_ACT0, lim(v));
		cmd(`CMD_START, 1'b0);
		apb(1'b0, `OFS_STAT0, '0);
		chk(32'(rd[31:16]), 32'(`ERR_HALT_START));
		cmd(`CMD_DECDONE, 1'b0);
		st(1'b0, 8'h01);
		chk(32'(axisPosDone[0]), '0);
		cmd(`CMD_HALT_OFF, 1'b0);
		report_and_stop();
	end
endmodule
`default_nettype wire
